// ===== rtl/asw_ctrl.v
// host controller driving an asynchronous byte-wide static memory
`timescale 1ns/1ns
`include "asw_regs.vh"
// Behaviour
// - overlapped low pulse of select and write strobe at least 40/50 ns.
// - address valid no later than write window start.
// - address held at least 50/60 ns before window end.
// - select asserted at least 50/60 ns before window end.
// - write data valid at least 25/30 ns before window end.
// - data and address may change right at the window end.
// - write recovery counted from first strobe rise, minimum zero.
// - controller never drives data while memory may drive it.
// - with output enable low, pulse covers setup plus float time.
// - in retention select stays high; other lines may float; here select floats with them (mem_ctl_oe low).
// - deselect no later than retention start, minimum zero.
module asw_ctrl (
	input wire clock,
	input wire rst_b,
	input wire req_valid,
	input wire req_write,
	input wire [`ASW_ADDR_W-1:0] req_addr,
	input wire [`ASW_DATA_W-1:0] req_wdata,
	input wire retain_req,
	output reg req_ready,
	output reg rsp_valid,
	output reg [`ASW_DATA_W-1:0] rsp_rdata,
	output reg retained,
	output reg [`ASW_ADDR_W-1:0] mem_addr,
	output reg [`ASW_ADDR_W-1:0] mem_addr_oe,
	output reg mem_cs_n,
	output reg mem_we_n,
	output reg mem_oe_n,
	output reg mem_ctl_oe,
	input wire [`ASW_DATA_W-1:0] mem_dq_in,
	output reg [`ASW_DATA_W-1:0] mem_dq_out,
	output reg mem_dq_oe
);

localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_WFLT = 6'h02;
localparam [5:0] ST_WDAT = 6'h04;
localparam [5:0] ST_RD = 6'h08;
localparam [5:0] ST_GAP = 6'h10;
localparam [5:0] ST_RET = 6'h20;

// cycle counts worked out from the ns figures at full integer width; each
// fits in eight bits, so the counters below are cut down on purpose
localparam integer FLT_N = `ASW_WRITE_FLOAT_CYC;
localparam integer SETUP_N = `ASW_DATA_SETUP_CYC;
localparam integer PULSE_N = `ASW_PULSE_CYC;
localparam integer CYCLE_N = `ASW_CYCLE_CYC;
localparam integer RD_N = `ASW_READ_WAIT_CYC;

// eight-bit limits compared against the cycle counters
localparam [7:0] FLT_CYC = FLT_N[7:0];
localparam [7:0] SETUP_CYC = SETUP_N[7:0];
localparam [7:0] PULSE_CYC = PULSE_N[7:0];
localparam [7:0] CYCLE_CYC = CYCLE_N[7:0];
localparam [7:0] RD_CYC = RD_N[7:0];

// true on the edge at which a count reaches its limit; the added one stands
// for the edge being taken now, since the counter only updates after it
function reached;
	input [7:0] count;
	input [7:0] limit;
	begin
		reached = (count + 8'h01) >= limit;
	end
endfunction

reg [5:0] state_reg;
reg [7:0] cnt_reg;
reg [7:0] span_reg;
reg [`ASW_DATA_W-1:0] dq_s1_reg;
reg [`ASW_DATA_W-1:0] dq_s2_reg;
reg retain_s1_reg;
reg retain_s2_reg;

// data pins from outside pass two flip-flops; first stage feeds only the second
// costs two cycles of read latency, paid in the read wait count
always @(posedge clock) begin
	dq_s1_reg <= mem_dq_in;
	dq_s2_reg <= dq_s1_reg;
end

// retention request arrives from another domain; same two-stage treatment
always @(posedge clock) begin
	retain_s1_reg <= retain_req;
	retain_s2_reg <= retain_s1_reg;
end

// one access engine; output enable stays high during writes, so the bus is
// released by the write strobe and the float wait below is always paid
always @(posedge clock) begin
	if (!rst_b) begin
		state_reg <= ST_IDLE;
		cnt_reg <= 8'h00;
		span_reg <= 8'h00;
		req_ready <= 1'b0;
		rsp_valid <= 1'b0;
		rsp_rdata <= 8'h00;
		retained <= 1'b0;
		mem_addr <= 19'h00000;
		mem_addr_oe <= 19'h00000;
		mem_cs_n <= 1'b1;
		mem_we_n <= 1'b1;
		mem_oe_n <= 1'b1;
		mem_ctl_oe <= 1'b1;
		mem_dq_out <= 8'h00;
		mem_dq_oe <= 1'b0;
	end else begin
		rsp_valid <= 1'b0;
		req_ready <= 1'b0;
		cnt_reg <= cnt_reg + 8'h01;
		span_reg <= span_reg + 8'h01;
		case (state_reg)
		ST_IDLE: begin
			cnt_reg <= 8'h00;
			if (retain_s2_reg) begin
				// deselect and let lines float on the same edge
				mem_cs_n <= 1'b1;
				mem_dq_oe <= 1'b0;
				mem_addr_oe <= 19'h00000;
				mem_ctl_oe <= 1'b0;
				retained <= 1'b1;
				state_reg <= ST_RET;
			end else if (req_valid && !req_ready) begin
				// address and select settle together, on the same edge as the strobe falls
				mem_addr <= req_addr;
				mem_addr_oe <= {`ASW_ADDR_W{1'b1}};
				mem_cs_n <= 1'b0;
				span_reg <= 8'h01;
				if (req_write) begin
					// select and write strobe fall on the same edge, so overlap starts on the strobe
					mem_we_n <= 1'b0;
					mem_dq_out <= req_wdata;
					state_reg <= ST_WFLT;
				end else begin
					mem_oe_n <= 1'b0;
					state_reg <= ST_RD;
				end
			end
		end
		ST_WFLT: begin
			// memory may still drive until it floats after the strobe
			// driving earlier would fight the memory's own output buffers
			if (reached(cnt_reg, FLT_CYC)) begin
				mem_dq_oe <= 1'b1;
				cnt_reg <= 8'h00;
				state_reg <= ST_WDAT;
			end
		end
		ST_WDAT: begin
			// pulse covers float time plus data setup, never below the minimum
			// span counts from the strobe fall but is held only to PULSE_CYC; select lead is met by float plus setup
			if (reached(cnt_reg, SETUP_CYC) && reached(span_reg, PULSE_CYC)) begin
				mem_we_n <= 1'b1;
				state_reg <= ST_GAP;
			end
		end
		ST_RD: begin
			// sample after output valid time plus two synchroniser stages
			// output enable drops with the sample; GAP lasts one cycle here, so the memory floats only after it
			if (reached(cnt_reg, RD_CYC)) begin
				rsp_rdata <= dq_s2_reg;
				rsp_valid <= 1'b1;
				mem_oe_n <= 1'b1;
				state_reg <= ST_GAP;
			end
		end
		ST_GAP: begin
			// data released one cycle after the window end: zero hold needed
			mem_dq_oe <= 1'b0;
			mem_cs_n <= 1'b1;
			// ready only once a whole cycle time has gone since select fell
			if (reached(span_reg, CYCLE_CYC)) begin
				req_ready <= 1'b1;
				state_reg <= ST_IDLE;
			end
		end
		ST_RET: begin
			// select is held high but floats with the control lines while mem_ctl_oe is low; a floating select could
			// let the memory wake and take stray strobes as a write
			cnt_reg <= 8'h00;
			if (!retain_s2_reg) begin
				mem_ctl_oe <= 1'b1;
				mem_addr_oe <= {`ASW_ADDR_W{1'b1}};
				retained <= 1'b0;
				span_reg <= 8'h00;
				state_reg <= ST_GAP; // recovery of one cycle time
			end
		end
		default: begin
			// illegal state: park the strobes inactive so no stray write lands
			state_reg <= ST_IDLE;
			mem_cs_n <= 1'b1;
			mem_we_n <= 1'b1;
			mem_oe_n <= 1'b1;
			mem_dq_oe <= 1'b0;
		end
		endcase
	end
end

endmodule

// ===== rtl/asw_regs.vh
// timing constants and widths for the static memory write controller
`ifndef ASW_REGS_VH
`define ASW_REGS_VH
`define ASW_ADDR_W 19
`define ASW_DATA_W 8
`define ASW_CLK_NS 10
// fast grade figures in ns (slow grade: 50, 60, 30, 30, 70, 35)
`define ASW_WRITE_PULSE_MIN_NS 40
`define ASW_CS_TO_END_MIN_NS 50
`define ASW_DATA_SETUP_TO_WRITE_END_NS 25
`define ASW_WRITE_TO_FLOAT_MAX_NS 20
`define ASW_READ_CYCLE_MIN_NS 55
`define ASW_OE_TO_VALID_MAX_NS 25
// least times round up to whole cycles
`define ASW_CEIL(ns) (((ns) + `ASW_CLK_NS - 1) / `ASW_CLK_NS)
`define ASW_WRITE_FLOAT_CYC `ASW_CEIL(`ASW_WRITE_TO_FLOAT_MAX_NS)
`define ASW_DATA_SETUP_CYC `ASW_CEIL(`ASW_DATA_SETUP_TO_WRITE_END_NS)
`define ASW_PULSE_CYC `ASW_CEIL(`ASW_WRITE_PULSE_MIN_NS)
`define ASW_CYCLE_CYC `ASW_CEIL(`ASW_READ_CYCLE_MIN_NS)
`define ASW_READ_WAIT_CYC (`ASW_CEIL(`ASW_OE_TO_VALID_MAX_NS) + 2)
`endif

// ===== verification/asw_ctrl_props.sv
// assertions on the controller's memory strobes
`timescale 1ns/1ns
`include "asw_regs.vh"
module asw_ctrl_props (
	input wire clock,
	input wire rst_b,
	input wire [`ASW_ADDR_W-1:0] mem_addr,
	input wire mem_cs_n,
	input wire mem_we_n,
	input wire mem_oe_n,
	input wire mem_dq_oe,
	input wire retained,
	input wire mem_ctl_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// write window closes as the write strobe rises under select
	sequence wr_end;
		$rose(mem_we_n) && !mem_cs_n;
	endsequence
	pulse_width_a: assert property ($fell(mem_we_n) |-> !(mem_we_n || mem_cs_n) [*4])
		else $error("write pulse short");
	cs_lead_a: assert property (wr_end |-> !$past(mem_cs_n, 5))
		else $error("select late");
	addr_lead_a: assert property (wr_end |-> $past(mem_addr, 5) == mem_addr)
		else $error("address moved");
	data_lead_a: assert property (wr_end |-> $past(mem_dq_oe, 3) && $past(mem_dq_oe))
		else $error("data late");
	no_fight_a: assert property (mem_dq_oe |-> mem_oe_n)
		else $error("bus contention");
	cycle_gap_a: assert property ($fell(mem_cs_n) |=> !$fell(mem_cs_n) [*5])
		else $error("cycles too close");
	retain_off_a: assert property (retained |-> mem_cs_n && !mem_ctl_oe)
		else $error("select in retention");
	recover_gap_a: assert property ($fell(retained) |-> !$fell(mem_cs_n) [*6])
		else $error("recovery short");
endmodule

// ===== verification/asw_ctrl_tb_top.sv
// self-checking bench for the static memory write controller
`timescale 1ns/1ns
`include "asw_regs.vh"
`define CHK(s, e, g) begin n_tests++; if ((e) !== (g)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", s, e, g); end end
module asw_ctrl_tb_top;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic req_valid = 1'h0;
	logic req_write = 1'h0;
	logic retain_req = 1'h0;
	logic [`ASW_ADDR_W-1:0] req_addr = 19'h0;
	logic [`ASW_DATA_W-1:0] req_wdata = 8'h0;
	logic [`ASW_ADDR_W-1:0] mem_addr, mem_addr_oe;
	logic [`ASW_DATA_W-1:0] rsp_rdata, mem_dq_in, mem_dq_out;
	logic req_ready, rsp_valid, retained, mem_cs_n, mem_we_n, mem_oe_n, mem_ctl_oe, mem_dq_oe;
	int miscompares = 0;
	int n_tests = 0;
	int n;
	int n_rsp = 0;
	always #5 clock = ~clock;
	// count read answer pulses as they stand
	always @(posedge clock) if (rsp_valid === 1'h1) n_rsp++;
	asw_ctrl u_asw_ctrl (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.retain_req(retain_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .retained(retained), .mem_addr(mem_addr),
		.mem_addr_oe(mem_addr_oe), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
		.mem_oe_n(mem_oe_n), .mem_ctl_oe(mem_ctl_oe), .mem_dq_in(mem_dq_in),
		.mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
	asw_mem_model u_asw_mem_model (.mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
		.mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_out(mem_dq_out),
		.mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
	task test_done;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// bounded wait for the ready pulse, counting cycles in n
	task wait_ready;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (req_ready !== 1'h1 && n < 40);
		`CHK("ready seen", 1'h1, req_ready)
	endtask
	// request is held until the edge that sees ready
	task acc(input logic w, input logic [`ASW_ADDR_W-1:0] ad, input logic [7:0] d);
		@(posedge clock);
		req_valid <= 1'h1;
		req_write <= w;
		req_addr <= ad;
		req_wdata <= d;
		wait_ready;
		req_valid <= 1'h0;
	endtask
	// back-to-back writes at the top address, 0x3ff and address 1, then read back
	task t_data;
		for (int i = 0; i < 3; i++) begin
			acc(1'h1, 19'h7ffff >> (9 * i), 8'ha5 ^ i[7:0]);
			`CHK("write span", 1'h1, n >= `ASW_CYCLE_CYC)
		end
		`CHK("no write answer", 0, n_rsp)
		for (int i = 0; i < 3; i++) begin
			acc(1'h0, 19'h7ffff >> (9 * i), 8'h00);
			`CHK("read data", 8'ha5 ^ i[7:0], rsp_rdata)
		end
		`CHK("read answers", 3, n_rsp)
	endtask
	// retention floats the lines; data must survive recovery
	task t_retain;
		@(posedge clock);
		retain_req <= 1'h1;
		repeat (8) @(posedge clock);
		`CHK("retained", 1'h1, retained)
		`CHK("cs high", 1'h1, mem_cs_n)
		`CHK("lines off", 20'h0, {mem_ctl_oe, mem_addr_oe})
		retain_req <= 1'h0;
		wait_ready;
		`CHK("recovery", 1'h1, n >= `ASW_CYCLE_CYC)
		acc(1'h0, 19'h3ff, 8'h00);
		`CHK("kept data", 8'ha4, rsp_rdata)
		`CHK("retain answers", 4, n_rsp)
	endtask
	// ceiling on clock cycles cuts a hang short
	initial begin
		repeat (3000) @(posedge clock);
		miscompares++;
		test_done;
	end
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'h1;
		t_data;
		t_retain;
		test_done;
	end
endmodule
bind asw_ctrl asw_ctrl_props u_asw_ctrl_props (.clock(clock), .rst_b(rst_b),
	.mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
	.mem_dq_oe(mem_dq_oe), .retained(retained), .mem_ctl_oe(mem_ctl_oe));

// ===== verification/asw_mem_model.sv
// behavioural byte-wide static memory facing the controller
`timescale 1ns/1ns
`include "asw_regs.vh"
module asw_mem_model (
	input wire [`ASW_ADDR_W-1:0] mem_addr,
	input wire mem_cs_n,
	input wire mem_we_n,
	input wire mem_oe_n,
	input wire [`ASW_DATA_W-1:0] mem_dq_out,
	input wire mem_dq_oe,
	output wire [`ASW_DATA_W-1:0] mem_dq_in
);
	logic [7:0] m [0:(1 << `ASW_ADDR_W) - 1];
	logic [7:0] val;
	logic [7:0] last = 8'h00;
	wire wr = !mem_cs_n && !mem_we_n;
	wire drv;
	// slowest valid and float times, so the host gets no slack
	assign #(25, 20) drv = !mem_cs_n && mem_we_n && !mem_oe_n;
	// last value on the bus before the first strobe rises is kept
	always @* begin
		if (wr) m[mem_addr] = mem_dq_oe ? mem_dq_out : ~mem_dq_out;
		val = m[mem_addr];
		if (drv) last = val;
	end
	// an undriven bus shows the inverse of the last value
	assign mem_dq_in = mem_dq_oe ? mem_dq_out : drv ? val : ~last;
endmodule
